/* File: src/prp_regs.svh */
`ifndef PRP_REGS_SVH
`define PRP_REGS_SVH

// ----------------------------------------
// pin and function geometry
// ----------------------------------------
`define PRP_NUM_PINS 26
`define PRP_NUM_IN 16
`define PRP_NUM_FUNC 32
`define PRP_PIN_PRESENT 26'h3ffefff
`define PRP_SEL_NONE 5'h1f
`define PRP_FUNC_NONE 5'h00
`define PRP_FUNC_UART1_TRANSMIT_OUT 5'h03
`define PRP_FUNC_UART1_REQUEST_TO_SEND_OUT 5'h04
`define PRP_IN_UART1_RECEIVE_IN 4'h0
`define PRP_IN_UART1_CLEAR_TO_SEND_IN 4'h1

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define PRP_CTRL_OFF 12'h000
`define PRP_PADS_OFF 12'h004
`define PRP_IN_BASE 12'h040
`define PRP_IN_REGS 12'h008
`define PRP_OUT_BASE 12'h080
`define PRP_OUT_REGS 12'h00d

// ----------------------------------------
// fields and keys
// ----------------------------------------
`define PRP_FLD_LO 0
`define PRP_FLD_HI 8
`define PRP_LOCK_BIT 6
`define PRP_KEY1 8'h46
`define PRP_KEY2 8'h57
`define PRP_RESP_OKAY 2'h0
`define PRP_RESP_SLVERR 2'h2

`endif

/* File: src/prp_pkg.sv */
package prp_pkg;
    typedef enum logic [1:0]
    {
        key_idle = 2'b00,
        key_half = 2'b01,
        key_open = 2'b10
    } prp_key_t;
endpackage

/* File: src/prp_pin_out_mux.sv */
`timescale 1ns/100ps
`default_nettype none
`include "prp_regs.svh"
module prp_pin_out_mux
    import prp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // selection
    input wire logic [4:0] func_sel,
    input wire logic [31:0] periph_out,
    // fixed functions on this pin
    input wire logic dedicated_en,
    input wire logic dedicated_out,
    input wire logic port_out,
    input wire logic port_dir_in,
    // pad
    output logic pad_out,
    output logic pad_oe
);
    wire remap_on = (func_sel != `PRP_FUNC_NONE);
    wire next_out = dedicated_en ? dedicated_out : (remap_on ? periph_out[func_sel] : port_out);
    wire next_oe = dedicated_en | remap_on | ~port_dir_in;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
        end
        else
        begin
            pad_out <= next_out;
            pad_oe <= next_oe;
        end
    end
endmodule
`default_nettype wire

/* File: src/prp_in_sel.sv */
`timescale 1ns/100ps
`default_nettype none
`include "prp_regs.svh"
module prp_in_sel
    import prp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // selection
    input wire logic [4:0] pin_sel,
    input wire logic [25:0] pad_in,
    input wire logic [25:0] analog_en,
    // peripheral input
    output logic periph_in
);
    localparam logic [25:0] present = `PRP_PIN_PRESENT;
    wire [31:0] present_x = {6'h00, present};
    wire [31:0] level_x = {6'h00, pad_in & ~analog_en};
    // out-of-range or missing pin reads low: no default connection
    wire next_in = present_x[pin_sel] & level_x[pin_sel];

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            periph_in <= 1'b0;
        else
            periph_in <= next_in;
    end
endmodule
`default_nettype wire

/* File: src/prp_pin_remap.sv */
// What this block does
// - remapping on up to 25 indexed pins
// - map each input and output independently
// - hardware lock guards mapping registers
// - remap only digital peripheral signals
// - no i2c, notify, alarm or analog signals
// - remapped functions start unconnected after reset
// - mapped output beats port and parallel port
// - dedicated outputs beat mapped outputs
// - remapped input never drives the pad
// - analog mode disables remapped input
// - fifth output register fields pins 8, 9
// - sixth output register fields pins 10, 11
// - bits 15-13 and 7-5 read zero
// - input field holds source pin index
// - function 3 uart tx, 4 rts
`timescale 1ns/100ps
`default_nettype none
`include "prp_regs.svh"
module prp_pin_remap
    import prp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // digital peripherals
    input wire logic [31:0] periph_out,
    output logic [15:0] periph_in,
    // port logic and fixed functions
    input wire logic [25:0] port_out,
    input wire logic [25:0] pin_direction_bit,
    input wire logic [25:0] dedicated_en,
    input wire logic [25:0] dedicated_out,
    input wire logic [25:0] analog_en,
    // pads
    input wire logic [25:0] pad_in,
    output logic [25:0] pad_out,
    output logic [25:0] pad_oe,
    // status
    output logic mapping_locked
);

    // ----------------------------------------
    // mapping state
    // ----------------------------------------
    logic [4:0] out_sel [0:25];
    logic [4:0] in_sel [0:15];
    prp_key_t key_state;
    prp_key_t next_key_state;

    // ----------------------------------------
    // write channel capture
    // ----------------------------------------
    logic aw_held;
    logic w_held;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_go = aw_held & w_held & ~s_axi_bvalid;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_held <= 1'b0;
            wr_addr <= 12'h000;
        end
        else if (aw_take)
        begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end
        else if (wr_go)
            aw_held <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            w_held <= 1'b0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end
        else if (w_take)
        begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
        else if (wr_go)
            w_held <= 1'b0;
    end

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    wire wr_aligned = (wr_addr[1:0] == 2'b00);
    wire [11:0] wr_out_off = wr_addr - `PRP_OUT_BASE;
    wire [11:0] wr_in_off = wr_addr - `PRP_IN_BASE;
    wire wr_ctrl_hit = (wr_addr == `PRP_CTRL_OFF);
    wire wr_pads_hit = (wr_addr == `PRP_PADS_OFF);
    wire wr_out_hit = wr_aligned & (wr_addr >= `PRP_OUT_BASE) & (wr_out_off[11:2] < `PRP_OUT_REGS);
    wire wr_in_hit = wr_aligned & (wr_addr >= `PRP_IN_BASE) & (wr_in_off[11:2] < `PRP_IN_REGS);
    wire wr_mapped = wr_ctrl_hit | wr_pads_hit | wr_out_hit | wr_in_hit;
    wire [3:0] wr_out_idx = wr_out_off[5:2];
    wire [2:0] wr_in_idx = wr_in_off[4:2];
    // writes to the map are dropped while locked, bus still answers okay
    wire map_wr_ok = wr_go & ~mapping_locked;
    wire ctrl_wr = wr_go & wr_ctrl_hit & wr_strb[0];
    wire [7:0] ctrl_byte = wr_data[7:0];

    localparam logic [25:0] pin_present = `PRP_PIN_PRESENT;

    logic [25:0] out_we;
    logic [15:0] in_we;
    logic [4:0] next_out_sel [0:25];
    logic [4:0] next_in_sel [0:15];

    // even entry sits in bits 4-0, odd entry in bits 12-8
    for (genvar p = 0; p < `PRP_NUM_PINS; p++)
    begin : g_out_we
        localparam int fld = (p % 2 == 0) ? `PRP_FLD_LO : `PRP_FLD_HI;
        assign out_we[p] = map_wr_ok & wr_out_hit & pin_present[p] & (32'(wr_out_idx) == p / 2)
            & wr_strb[fld / 8];
        assign next_out_sel[p] = wr_data[fld +: 5];
    end

    for (genvar q = 0; q < `PRP_NUM_IN; q++)
    begin : g_in_we
        localparam int fld = (q % 2 == 0) ? `PRP_FLD_LO : `PRP_FLD_HI;
        assign in_we[q] = map_wr_ok & wr_in_hit & (32'(wr_in_idx) == q / 2) & wr_strb[fld / 8];
        assign next_in_sel[q] = wr_data[fld +: 5];
    end

    // ----------------------------------------
    // mapping registers
    // ----------------------------------------
    // unconnected after reset: outputs select nothing, inputs a pin that is not there
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < `PRP_NUM_PINS; i++)
                out_sel[i] <= `PRP_FUNC_NONE;
            for (int j = 0; j < `PRP_NUM_IN; j++)
                in_sel[j] <= `PRP_SEL_NONE;
        end
        else
        begin
            for (int i = 0; i < `PRP_NUM_PINS; i++)
                if (out_we[i])
                    out_sel[i] <= next_out_sel[i];
            for (int j = 0; j < `PRP_NUM_IN; j++)
                if (in_we[j])
                    in_sel[j] <= next_in_sel[j];
        end
    end

    // ----------------------------------------
    // lock key sequence
    // ----------------------------------------
    // any write that breaks the sequence drops back to idle, except a repeated first key, which stays half way
    always_comb
    begin
        next_key_state = key_state;
        if (wr_go)
        begin
            unique case (key_state)
                key_idle:
                    next_key_state = (ctrl_wr && ctrl_byte == `PRP_KEY1) ? key_half : key_idle;
                key_half:
                    if (ctrl_wr && ctrl_byte == `PRP_KEY2)
                        next_key_state = key_open;
                    else if (ctrl_wr && ctrl_byte == `PRP_KEY1)
                        next_key_state = key_half;
                    else
                        next_key_state = key_idle;
                key_open:
                    next_key_state = key_idle;
                default:
                    next_key_state = key_idle;
            endcase
        end
    end

    wire lock_load = ctrl_wr & (key_state == key_open);

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            key_state <= key_idle;
        else
            key_state <= next_key_state;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            mapping_locked <= 1'b0;
        else if (lock_load)
            mapping_locked <= ctrl_byte[`PRP_LOCK_BIT];
    end

    // ----------------------------------------
    // write response
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PRP_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `PRP_RESP_OKAY : `PRP_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;
    wire rd_take = s_axi_arvalid & s_axi_arready;

    wire rd_aligned = (s_axi_araddr[1:0] == 2'b00);
    wire [11:0] rd_out_off = s_axi_araddr - `PRP_OUT_BASE;
    wire [11:0] rd_in_off = s_axi_araddr - `PRP_IN_BASE;
    wire rd_ctrl_hit = (s_axi_araddr == `PRP_CTRL_OFF);
    wire rd_pads_hit = (s_axi_araddr == `PRP_PADS_OFF);
    wire rd_out_hit = rd_aligned & (s_axi_araddr >= `PRP_OUT_BASE) & (rd_out_off[11:2] < `PRP_OUT_REGS);
    wire rd_in_hit = rd_aligned & (s_axi_araddr >= `PRP_IN_BASE) & (rd_in_off[11:2] < `PRP_IN_REGS);
    wire rd_mapped = rd_ctrl_hit | rd_pads_hit | rd_out_hit | rd_in_hit;
    wire [3:0] rd_out_idx = rd_out_off[5:2];
    wire [2:0] rd_in_idx = rd_in_off[4:2];

    // out index tops at 12 and in index at 7, so both entries always exist
    wire [4:0] rd_out_lo = out_sel[{rd_out_idx, 1'b0}];
    wire [4:0] rd_out_hi = out_sel[{rd_out_idx, 1'b1}];
    wire [4:0] rd_in_lo = in_sel[{rd_in_idx, 1'b0}];
    wire [4:0] rd_in_hi = in_sel[{rd_in_idx, 1'b1}];

    wire [31:0] rd_ctrl_word = {24'h00_0000, 1'b0, mapping_locked, 6'h00};
    wire [31:0] rd_pads_word = {6'h00, pad_in & pin_present};
    wire [31:0] rd_out_word = {16'h0000, 3'h0, rd_out_hi, 3'h0, rd_out_lo};
    wire [31:0] rd_in_word = {16'h0000, 3'h0, rd_in_hi, 3'h0, rd_in_lo};

    wire [31:0] rd_word = rd_ctrl_hit ? rd_ctrl_word :
                          rd_pads_hit ? rd_pads_word :
                          rd_out_hit ? rd_out_word :
                          rd_in_hit ? rd_in_word : 32'h0000_0000;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PRP_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? `PRP_RESP_OKAY : `PRP_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ----------------------------------------
    // output matrix
    // ----------------------------------------
    // only digital function numbers reach the matrix; i2c, notify and alarm stay on fixed pins
    for (genvar p = 0; p < `PRP_NUM_PINS; p++)
    begin : g_pin_out
        prp_pin_out_mux u_out
        (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .func_sel(out_sel[p]),
            .periph_out(periph_out),
            .dedicated_en(dedicated_en[p]),
            .dedicated_out(dedicated_out[p]),
            .port_out(port_out[p]),
            .port_dir_in(pin_direction_bit[p]),
            .pad_out(pad_out[p]),
            .pad_oe(pad_oe[p])
        );
    end

    // ----------------------------------------
    // input matrix
    // ----------------------------------------
    // timer clock inputs see nothing until software routes them
    for (genvar q = 0; q < `PRP_NUM_IN; q++)
    begin : g_pin_in
        prp_in_sel u_in
        (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .pin_sel(in_sel[q]),
            .pad_in(pad_in),
            .analog_en(analog_en),
            .periph_in(periph_in[q])
        );
    end

endmodule
`default_nettype wire

/* File: verif/prp_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module prp_far_model
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // pads
    input wire logic [25:0] pad_out,
    input wire logic [25:0] pad_oe,
    input wire logic [25:0] ext_level,
    output logic [25:0] pad_in,
    // peripheral outputs
    output logic [31:0] periph_out
);
    // ------------
    // peripherals
    // ------------
    // new pattern every cycle, so a late or stale select cannot pass
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            periph_out <= 32'h5a3c96e1;
        else
            periph_out <= periph_out + 32'h9e3779b9;
    // undriven pads follow the board
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule
`default_nettype wire

/* File: verif/prp_pin_remap_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module prp_pin_remap_checker
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pins
    input wire logic [25:0] dedicated_en,
    input wire logic [25:0] dedicated_out,
    input wire logic [25:0] analog_en,
    input wire logic [25:0] pad_out,
    input wire logic [25:0] pad_oe,
    input wire logic [15:0] periph_in,
    input wire logic mapping_locked
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_ded_wins;
        dedicated_en != 26'h0 |=> ((pad_oe & $past(dedicated_en)) == $past(dedicated_en))
            && (((pad_out ^ $past(dedicated_out)) & $past(dedicated_en)) == 26'h0);
    endproperty
    a_ded_wins: assert property (p_ded_wins) else $error("dedicated output lost its pin");
    // lock may only move at the edge a write completes
    property p_lock_moves;
        $changed(mapping_locked) |-> $rose(s_axi_bvalid);
    endproperty
    a_lock_moves: assert property (p_lock_moves) else $error("lock changed without a write");
    property p_analog_off;
        analog_en == 26'h3ffffff |=> periph_in == 16'h0;
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("input live on analog pin");
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_once: assert property (p_b_once) else $error("write response repeated");
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_once: assert property (p_r_once) else $error("read response repeated");
    property p_ar_block;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && !s_axi_arready && $stable(s_axi_rdata);
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_wr_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
endmodule
bind prp_pin_remap prp_pin_remap_checker i_prp_pin_remap_checker (.core_clk, .arst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .dedicated_en, .dedicated_out, .analog_en, .pad_out, .pad_oe, .periph_in,
    .mapping_locked, .s_axi_rdata);
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "prp_regs.svh"
module testbench;
    logic core_clk = 1'h0, arst_n = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, periph_out, pq;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mapping_locked;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] periph_in;
    logic [25:0] port_out = 26'h0, pin_direction_bit = 26'h3ffffff, dedicated_en = 26'h0, dedicated_out = 26'h0;
    logic [25:0] analog_en = 26'h0, ext_level = 26'h0, pad_in, pad_out, pad_oe, iq, aq;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int miscompares = 0, num_checks = 0, cyc = 0;
    prp_pin_remap i_prp_pin_remap (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .periph_out, .periph_in, .port_out, .pin_direction_bit, .dedicated_en, .dedicated_out, .analog_en,
        .pad_in, .pad_out, .pad_oe, .mapping_locked);
    prp_far_model i_prp_far_model (.core_clk, .arst_n, .pad_out, .pad_oe, .ext_level, .pad_in, .periph_out);
    initial
        forever #10 core_clk = ~core_clk;
    // ------------
    // helpers
    // ------------
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // address and data go out together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw;
        pa = 1'h1;
        pw = 1'h1;
        bq.push_back(`PRP_RESP_OKAY);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (pa || pw)
        begin
            @(negedge core_clk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge core_clk);
            if (ta)
                s_axi_awvalid <= 1'h0;
            if (tw)
                s_axi_wvalid <= 1'h0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do
            @(negedge core_clk);
        while (!s_axi_bvalid);
        @(posedge core_clk);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        logic t;
        rq.push_back(e);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do
        begin
            @(negedge core_clk);
            t = s_axi_arready;
            @(posedge core_clk);
        end
        while (!t);
        s_axi_arvalid <= 1'h0;
        // a random stall makes the answer stand until it is taken
        if ($urandom % 2 == 1)
            @(posedge core_clk);
        s_axi_rready <= 1'h1;
        do
            @(negedge core_clk);
        while (!s_axi_rvalid);
        @(posedge core_clk);
        s_axi_rready <= 1'h0;
    endtask
    task automatic keyed(input logic [31:0] v);
        wr(`PRP_CTRL_OFF, 32'(`PRP_KEY1));
        wr(`PRP_CTRL_OFF, 32'(`PRP_KEY2));
        wr(`PRP_CTRL_OFF, v);
    endtask
    // capture what the design samples, then look once it has landed
    task automatic settle();
        repeat (3) @(posedge core_clk);
        pq = periph_out;
        iq = pad_in;
        aq = analog_en;
        @(negedge core_clk);
    endtask
    // ------------
    // monitor
    // ------------
    always @(posedge core_clk)
    begin
        cyc++;
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            chk(s_axi_bresp, bq.pop_front());
        if (cyc == 5000)
        begin
            miscompares++;
            finish_test();
        end
    end
    // ------------
    // tests
    // ------------
    initial
    begin
        pq = $urandom(77);
        repeat (6) @(posedge core_clk);
        arst_n <= 1'h1;
        rd(12'h090, 34'h0);
        rd(12'h094, 34'h0);
        rd(`PRP_IN_BASE, 34'h1f1f);
        rd(`PRP_CTRL_OFF, 34'h0);
        rd(12'hffc, {`PRP_RESP_SLVERR, 32'h0});
        chk(periph_in, 16'h0);
        chk(pad_oe, 26'h0);
        $display("test reset_state done");
        wr(12'h090, 32'hffffe4e3);
        rd(12'h090, 34'h403);
        pq = $urandom;
        wr(12'h094, pq);
        rd(12'h094, {2'h0, pq & 32'h1f1f});
        s_axi_wstrb <= 4'h2;
        wr(12'h094, 32'h1f1f);
        rd(12'h094, {2'h0, 32'h1f00 | pq & 32'h001f});
        s_axi_wstrb <= 4'hf;
        wr(12'h094, 32'h0);
        $display("test out_regs done");
        @(posedge core_clk);
        pin_direction_bit <= 26'h3fff8ff;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            port_out <= 26'($urandom);
            dedicated_out <= 26'($urandom);
            dedicated_en <= i[0] ? 26'h200 : 26'h0;
            settle();
            chk({pad_oe[8], pad_out[8]}, {1'h1, pq[3]});
            chk({pad_oe[9], pad_out[9]}, {1'h1, i[0] ? dedicated_out[9] : pq[4]});
            chk({pad_oe[11:10], pad_out[10]}, {2'h1, port_out[10]});
        end
        $display("test pin_priority done");
        wr(`PRP_IN_BASE, 32'h0105);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge core_clk);
            ext_level <= 26'($urandom);
            analog_en <= (i == 5) ? 26'h3ffffff : 26'($urandom) & 26'h22;
            settle();
            chk(periph_in[1:0], {iq[1] & !aq[1], iq[5] & !aq[5]});
            chk({pad_oe[5], pad_oe[1]}, 2'h0);
        end
        @(posedge core_clk);
        analog_en <= 26'h0;
        $display("test input_map done");
        wr(`PRP_CTRL_OFF, 32'h40);
        rd(`PRP_CTRL_OFF, 34'h0);
        keyed(32'h40);
        chk(mapping_locked, 1'h1);
        wr(12'h090, 32'h0);
        rd(12'h090, 34'h403);
        keyed(32'h0);
        chk(mapping_locked, 1'h0);
        wr(12'h090, 32'h0);
        rd(12'h090, 34'h0);
        iq = pin_direction_bit & ext_level | ~pin_direction_bit & port_out;
        iq = dedicated_en & dedicated_out | ~dedicated_en & iq;
        rd(`PRP_PADS_OFF, {8'h0, iq & `PRP_PIN_PRESENT});
        $display("test lock done");
        finish_test();
    end
endmodule
`default_nettype wire
